//--- logic/spi_card_pkg.sv
// constants, register map and types shared by the card host controller
// assumes a card in spi mode on the far side, crc checking off after reset
package spi_card_pkg;
  // ***********************
  // register map (byte addresses)
  // ***********************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD  = 8'h04;
  localparam logic [7:0] OFF_ARG  = 8'h08;
  localparam logic [7:0] OFF_BCNT = 8'h0c;
  localparam logic [7:0] OFF_BLEN = 8'h10;
  localparam logic [7:0] OFF_TX   = 8'h14;
  localparam logic [7:0] OFF_RX   = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  localparam int CTL_GO   = 0;
  localparam int CTL_OP   = 1;
  localparam int CTL_CNT  = 4;
  localparam int CTL_STOP = 5;
  // ***********************
  // command indices and frame layout
  // ***********************
  localparam logic [5:0] IDX_RESET  = 6'h00;
  localparam logic [5:0] IDX_INIT   = 6'h01;
  localparam logic [5:0] IDX_HALT   = 6'h0c;
  localparam logic [5:0] IDX_STATUS = 6'h0d;
  localparam logic [5:0] IDX_RDM    = 6'h12;
  localparam logic [5:0] IDX_COUNT  = 6'h17;
  localparam logic [5:0] IDX_WRM    = 6'h19;
  localparam logic [1:0] FRM_HEAD   = 2'h1;
  localparam logic       FRM_END    = 1'h1;
  localparam logic [6:0] CRC7_POLY  = 7'h09;
  localparam logic [2:0] FRAME_LAST = 3'h5;
  localparam logic [7:0] CRC_FILL   = 8'hff;
  localparam int         CRC_BYTES  = 2;
  // ***********************
  // token byte values
  // ***********************
  localparam logic [7:0] TOK_START  = 8'hfe;
  localparam logic [7:0] TOK_MSTART = 8'hfc;
  localparam logic [7:0] TOK_STOP   = 8'hfd;
  localparam logic [7:0] TOK_BUSY   = 8'h00;
  localparam logic [7:0] TOK_IDLE   = 8'hff;
  localparam logic [7:0] ERR_MASK   = 8'hf0;
  localparam logic [7:0] DRESP_MASK = 8'h1f;
  localparam logic [7:0] DRESP_OK   = 8'h05;
  localparam logic [7:0] R1_ERRS    = 8'h7e;
  localparam int         R1_IDLE    = 0;
  localparam int         R1_MARK    = 7;
  typedef enum logic [3:0] {S_IDLE, S_CMD, S_RESP, S_RESP2, S_TOK, S_RD, S_WTOK,
                            S_WR, S_DRESP, S_BUSY, S_TAIL} state_t;
  typedef enum logic [2:0] {P_PRE, P_MAIN, P_STOP, P_STAT, P_RESET, P_POLL} phase_t;
  typedef enum logic [2:0] {OP_CMD, OP_BUSY, OP_READ, OP_WRITE, OP_INIT} op_t;
endpackage

//--- logic/spi_byte_shift.sv
// one spi byte exchange, mode 0, msb first, host-made serial clock
// assumes start is only pulsed while no exchange runs
`timescale 1ns/1ps
module spi_byte_shift
  import spi_card_pkg::*;
#(
  parameter int HALF = 4
)(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [7:0] txByte,
  output logic      [7:0] rxByte,
  output logic            done,
  output logic            sclk,
  output logic            mosi,
  input  wire logic       miso
);
  logic       misoMeta;
  logic       misoSync;
  logic       active;
  logic [7:0] sh;
  logic [7:0] rx;
  logic [2:0] bitCnt;
  logic [7:0] divCnt;
  // two flops on the card data pin before anything reads it
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      misoMeta <= 1'b1;
      misoSync <= 1'b1;
    end
    else if (ce)
    begin
      misoMeta <= miso;
      misoSync <= misoMeta;
    end
  end
  // sample at the end of the high phase so the sync lag stays inside it
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      active <= 1'b0;
      sclk   <= 1'b0;
      mosi   <= 1'b1;
      sh     <= '0;
      rx     <= '0;
      rxByte <= '0;
      bitCnt <= '0;
      divCnt <= '0;
      done   <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start && !active)
      begin
        active <= 1'b1;
        sh     <= txByte;
        mosi   <= txByte[7];
        bitCnt <= '0;
        divCnt <= '0;
      end
      else if (active)
      begin
        if (divCnt != 8'(HALF - 1))
          divCnt <= divCnt + 8'h01;
        else
        begin
          divCnt <= '0;
          sclk   <= !sclk;
          if (sclk)
          begin
            rx     <= {rx[6:0], misoSync};
            sh     <= {sh[6:0], 1'b1};
            mosi   <= sh[6];
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7)
            begin
              active <= 1'b0;
              done   <= 1'b1;
              mosi   <= 1'b1;
              rxByte <= {rx[6:0], misoSync};
            end
          end
        end
      end
    end
  end
endmodule

//--- logic/spi_card_host.sv
// host controller for a memory card in spi mode, apb slave for software
// assumes a card on csN/sclk/mosi/miso and software that polls status
`timescale 1ns/1ps
module spi_card_host
  import spi_card_pkg::*;
#(
  parameter int HALF_DIV    = 4,
  parameter int RESP_LIMIT  = 8,
  parameter int TOKEN_LIMIT = 1024,
  parameter int POLL_LIMIT  = 1000,
  parameter int LEN_W       = 10,
  parameter int CNT_W       = 16
)(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             csN,
  output logic             sclk,
  output logic             mosi,
  input  wire logic        miso
);
  // ***********************
  // declarations
  // ***********************
  localparam int WAIT_W = $clog2(TOKEN_LIMIT + POLL_LIMIT + 1);
  state_t             state;
  phase_t             phase;
  op_t                op;
  logic [47:0]        frame;
  logic [2:0]         fIdx;
  logic               waiting;
  logic               engStart;
  logic [7:0]         engTx;
  logic [7:0]         rxB;
  logic               engDone;
  logic               canGo;
  logic [5:0]         cmdIdx_reg;
  logic [31:0]        arg_reg;
  logic [CNT_W-1:0]   blkCnt_reg;
  logic [LEN_W-1:0]   blkLen_reg;
  logic [7:0]         txData_reg;
  logic               txFull;
  logic [7:0]         rxData_reg;
  logic               rxValid;
  logic               counted;
  logic               stopReq;
  logic               stopSent;
  logic               busySeen;
  logic               errTok;
  logic               wrErr;
  logic               tmo;
  logic [7:0]         r1_reg;
  logic [7:0]         tokByte_reg;
  logic [7:0]         stat2_reg;
  logic [CNT_W-1:0]   blkDone;
  logic [LEN_W:0]     byteCnt;
  logic [WAIT_W-1:0]  waitCnt;
  logic [WAIT_W-1:0]  pollCnt;
  logic               apbAcc;
  logic               apbWr;
  logic               goReq;
  logic               multi;
  logic               inData;
  logic               lastCrc;
  logic               issue;
  logic               lastBlk;

  // ***********************
  // helpers
  // ***********************
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = '0;
    for (int i = 39; i >= 0; i--)
    begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb)
        c = c ^ CRC7_POLY;
    end
    return c;
  endfunction

  function automatic logic [47:0] frameOf(input logic [5:0] idx, input logic [31:0] a);
    return {FRM_HEAD, idx, a, crc7({FRM_HEAD, idx, a}), FRM_END};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_CMD || a == OFF_ARG || a == OFF_BCNT ||
           a == OFF_BLEN || a == OFF_TX || a == OFF_RX || a == OFF_STAT;
  endfunction

  assign apbAcc  = psel && penable && pready;
  assign apbWr   = apbAcc && pwrite;
  assign goReq   = apbWr && paddr == OFF_CTRL && pwdata[CTL_GO] && state == S_IDLE;
  assign multi   = cmdIdx_reg == IDX_RDM || cmdIdx_reg == IDX_WRM;
  assign inData  = byteCnt < (LEN_W+1)'(blkLen_reg);
  assign lastCrc = byteCnt == (LEN_W+1)'(blkLen_reg) + (LEN_W+1)'(CRC_BYTES - 1);
  assign issue   = state != S_IDLE && !waiting && !engStart && canGo;
  assign lastBlk = counted && blkDone + CNT_W'(1) == blkCnt_reg;

  // ***********************
  // byte engine
  // ***********************
  spi_byte_shift #(
    .HALF (HALF_DIV)
  ) u_shift (
    .mclk   (mclk),
    .nrst   (nrst),
    .ce     (ce),
    .start  (engStart),
    .txByte (engTx),
    .rxByte (rxB),
    .done   (engDone),
    .sclk   (sclk),
    .mosi   (mosi),
    .miso   (miso)
  );

  // byte to send next; data bytes wait for software so the link stalls
  always_comb
  begin
    canGo = 1'b1;
    engTx = TOK_IDLE;
    unique case (state)
      S_IDLE:  canGo = 1'b0;
      S_CMD:   engTx = frame[47:40];
      S_RD:    canGo = !rxValid;
      S_WTOK:
      begin
        // stop token replaces the next start token
        if (wrErr || (stopReq && !counted))
          engTx = TOK_STOP;
        else
          engTx = multi ? TOK_MSTART : TOK_START;
      end
      S_WR:
      begin
        canGo = !inData || txFull;
        engTx = inData ? txData_reg : CRC_FILL;
      end
      S_RESP, S_RESP2, S_TOK, S_DRESP, S_BUSY, S_TAIL: engTx = TOK_IDLE;
    endcase
  end

  // ***********************
  // apb slave
  // ***********************
  // answer registered in setup, so every access completes in one access cycle
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      unique case (paddr)
        OFF_CMD:  prdata <= 32'(cmdIdx_reg);
        OFF_ARG:  prdata <= arg_reg;
        OFF_BCNT: prdata <= 32'(blkCnt_reg);
        OFF_BLEN: prdata <= 32'(blkLen_reg);
        OFF_RX:   prdata <= 32'(rxData_reg);
        OFF_STAT: prdata <= {stat2_reg, tokByte_reg, r1_reg, 2'h0, tmo, wrErr,
                             errTok, rxValid, txFull, state != S_IDLE};
        default:  prdata <= '0;
      endcase
    end
  end

  // configuration written by software
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cmdIdx_reg <= '0;
      arg_reg    <= '0;
      blkCnt_reg <= '0;
      blkLen_reg <= '0;
      stopReq    <= 1'b0;
      op         <= OP_CMD;
      counted    <= 1'b0;
    end
    else if (ce && apbWr)
    begin
      unique case (paddr)
        OFF_CMD:  cmdIdx_reg <= pwdata[5:0];
        OFF_ARG:  arg_reg <= pwdata;
        OFF_BCNT: blkCnt_reg <= pwdata[CNT_W-1:0];
        OFF_BLEN: blkLen_reg <= pwdata[LEN_W-1:0];
        OFF_CTRL:
        begin
          stopReq <= pwdata[CTL_STOP];
          if (goReq)
          begin
            op      <= op_t'(pwdata[CTL_OP +: 3]);
            counted <= pwdata[CTL_CNT];
          end
        end
        default: ;
      endcase
    end
  end

  // write byte holding register; a new write wins over the take
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      txData_reg <= '0;
      txFull     <= 1'b0;
    end
    else if (ce)
    begin
      if (apbWr && paddr == OFF_TX)
      begin
        txData_reg <= pwdata[7:0];
        txFull     <= 1'b1;
      end
      else if (issue && state == S_WR && inData)
        txFull <= 1'b0;
    end
  end

  // read byte holding register; arrival wins over the software read
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rxData_reg <= '0;
      rxValid    <= 1'b0;
    end
    else if (ce)
    begin
      if (engDone && state == S_RD && inData)
      begin
        rxData_reg <= rxB;
        rxValid    <= 1'b1;
      end
      else if (apbAcc && !pwrite && paddr == OFF_RX)
        rxValid <= 1'b0;
    end
  end

  // ***********************
  // chip select
  // ***********************
  // select dropped for the trailing 8 clocks
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      csN <= 1'b1;
    else if (ce)
      csN <= state == S_IDLE || state == S_TAIL;
  end

  // ***********************
  // transaction sequencer
  // ***********************
  // whole bytes only, one engine exchange at a time
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state       <= S_IDLE;
      phase       <= P_MAIN;
      frame       <= '0;
      fIdx        <= '0;
      waiting     <= 1'b0;
      engStart    <= 1'b0;
      stopSent    <= 1'b0;
      busySeen    <= 1'b0;
      errTok      <= 1'b0;
      wrErr       <= 1'b0;
      tmo         <= 1'b0;
      r1_reg      <= '0;
      tokByte_reg <= '0;
      stat2_reg   <= '0;
      blkDone     <= '0;
      byteCnt     <= '0;
      waitCnt     <= '0;
      pollCnt     <= '0;
    end
    else if (ce)
    begin
      engStart <= issue;
      if (issue)
        waiting <= 1'b1;
      if (goReq)
      begin
        errTok   <= 1'b0;
        wrErr    <= 1'b0;
        tmo      <= 1'b0;
        stopSent <= 1'b0;
        blkDone  <= '0;
        fIdx     <= '0;
        waitCnt  <= '0;
        pollCnt  <= '0;
        state    <= S_CMD;
        // reset command aborts card programming; host owns the risk
        if (op_t'(pwdata[CTL_OP +: 3]) == OP_INIT)
        begin
          frame <= frameOf(IDX_RESET, '0);
          phase <= P_RESET;
        end
        // block count goes directly before the multi command
        else if (pwdata[CTL_CNT] && multi)
        begin
          frame <= frameOf(IDX_COUNT, 32'(blkCnt_reg));
          phase <= P_PRE;
        end
        else
        begin
          frame <= frameOf(cmdIdx_reg, arg_reg);
          phase <= P_MAIN;
        end
      end
      else if (engDone)
      begin
        waiting <= 1'b0;
        unique case (state)
          S_CMD:
          begin
            frame <= {frame[39:0], 8'h00};
            fIdx  <= fIdx + 3'h1;
            if (fIdx == FRAME_LAST)
            begin
              state   <= S_RESP;
              waitCnt <= '0;
            end
          end
          S_RESP:
          begin
            if (!rxB[R1_MARK])
            begin
              // checksum and illegal flags kept for software
              r1_reg  <= rxB;
              fIdx    <= '0;
              waitCnt <= '0;
              unique case (phase)
                // poll init until the idle bit clears
                P_RESET:
                begin
                  frame <= frameOf(IDX_INIT, '0);
                  phase <= P_POLL;
                  state <= S_CMD;
                end
                P_POLL:
                begin
                  // own poll counter, the response wait clears waitCnt every frame
                  if (rxB[R1_IDLE] && pollCnt != WAIT_W'(POLL_LIMIT - 1))
                  begin
                    frame   <= frameOf(IDX_INIT, '0);
                    state   <= S_CMD;
                    pollCnt <= pollCnt + WAIT_W'(1);
                  end
                  else
                  begin
                    tmo   <= rxB[R1_IDLE];
                    state <= S_TAIL;
                  end
                end
                P_PRE:
                begin
                  if ((rxB & R1_ERRS) != '0)
                    state <= S_TAIL;
                  else
                  begin
                    frame <= frameOf(cmdIdx_reg, arg_reg);
                    phase <= P_MAIN;
                    state <= S_CMD;
                  end
                end
                P_MAIN:
                begin
                  busySeen <= 1'b0;
                  if ((rxB & R1_ERRS) != '0)
                    state <= S_TAIL;
                  else
                    unique case (op)
                      OP_BUSY:  state <= S_BUSY;
                      // register reads run as plain block reads
                      OP_READ:  state <= S_TOK;
                      // after the write response, send the block
                      OP_WRITE: state <= S_WTOK;
                      default:  state <= S_TAIL;
                    endcase
                end
                P_STOP:
                begin
                  busySeen <= 1'b0;
                  state    <= S_BUSY;
                end
                P_STAT:   state <= S_RESP2;
              endcase
            end
            else if (waitCnt == WAIT_W'(RESP_LIMIT - 1))
            begin
              tmo   <= 1'b1;
              state <= S_TAIL;
            end
            else
              waitCnt <= waitCnt + WAIT_W'(1);
          end
          S_RESP2:
          begin
            stat2_reg <= rxB;
            state     <= S_TAIL;
          end
          S_TOK:
          begin
            if (rxB == TOK_START)
            begin
              byteCnt <= '0;
              state   <= S_RD;
            end
            // error token stands in for the block
            else if ((rxB & ERR_MASK) == '0)
            begin
              // address error bit kept in the token byte
              errTok      <= 1'b1;
              tokByte_reg <= rxB;
              fIdx        <= '0;
              // abort the multi read with the halt command
              if (multi)
              begin
                frame <= frameOf(IDX_HALT, '0);
                phase <= P_STOP;
                state <= S_CMD;
              end
              else
                state <= S_TAIL;
            end
            else if (waitCnt == WAIT_W'(TOKEN_LIMIT - 1))
            begin
              tmo   <= 1'b1;
              state <= S_TAIL;
            end
            else
              waitCnt <= waitCnt + WAIT_W'(1);
          end
          S_RD:
          begin
            byteCnt <= byteCnt + (LEN_W+1)'(1);
            if (lastCrc)
            begin
              blkDone <= blkDone + CNT_W'(1);
              waitCnt <= '0;
              fIdx    <= '0;
              // counted read ends itself after the last block
              // so no halt command follows it
              if (!multi || lastBlk)
                state <= S_TAIL;
              else if (stopReq)
              begin
                frame <= frameOf(IDX_HALT, '0);
                phase <= P_STOP;
                state <= S_CMD;
              end
              else
                state <= S_TOK;
            end
          end
          S_WTOK:
          begin
            byteCnt  <= '0;
            busySeen <= 1'b0;
            if (engTx == TOK_STOP)
            begin
              stopSent <= 1'b1;
              state    <= S_BUSY;
            end
            else
              state <= S_WR;
          end
          S_WR:
          begin
            byteCnt <= byteCnt + (LEN_W+1)'(1);
            if (lastCrc)
              state <= S_DRESP;
          end
          S_DRESP:
          begin
            // rejected block reported here and not programmed
            // misalignment also shows as a rejection
            tokByte_reg <= rxB;
            if ((rxB & DRESP_MASK) != DRESP_OK)
              wrErr <= 1'b1;
            blkDone  <= blkDone + CNT_W'(1);
            busySeen <= 1'b0;
            state    <= S_BUSY;
          end
          S_BUSY:
          begin
            // wait while the card holds its output low
            // keep clocking, release comes on an edge
            busySeen <= 1'b1;
            if (rxB != TOK_BUSY && busySeen)
            begin
              fIdx <= '0;
              // after a write error only the stop token follows
              // counted write ends without a stop token
              // a stop token after the last counted block only on a write error
              if (op == OP_WRITE && multi && !stopSent &&
                  (wrErr || !(counted && blkDone == blkCnt_reg)))
                state <= S_WTOK;
              // ask status once programming is over
              else if (op == OP_WRITE)
              begin
                frame <= frameOf(IDX_STATUS, '0);
                phase <= P_STAT;
                state <= S_CMD;
              end
              else
                state <= S_TAIL;
            end
          end
          S_TAIL:  state <= S_IDLE;
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule

//--- sim/spi_card_host_asserts.sv
// port checker for the card host controller
// assumes bind beside spi_card_host; checks pause while ce is low
`timescale 1ns/1ps
module spi_card_host_asserts (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        csN,
  input wire logic        sclk,
  input wire logic        mosi,
  input wire logic [31:0] prdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst || !ce);
  // zero wait states, one access cycle
  ack_setup_a: assert property (psel && !penable |=> pready) else $error("late ready");
  ack_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  err_data_a: assert property (pslverr |-> pready && prdata == 0) else $error("bad slverr");
  // deselected line idles high, tail byte too
  idle_high_a: assert property (csN |-> mosi) else $error("mosi low");
  bit_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("mosi moved");
  half_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("high half");
  half_low_a: assert property ($fell(sclk) |-> !sclk[*4]) else $error("low half");
  // every transaction opens with a frame start bit
  frame_start_a: assert property ($fell(csN) |-> ##[1:12] ($rose(sclk) && !mosi))
    else $error("no start bit");
  cover property (pslverr);
  cover property ($fell(csN));
  cover property ($rose(csN));
endmodule
bind spi_card_host spi_card_host_asserts u_chk (.mclk, .nrst, .ce, .psel, .penable, .pready,
  .pslverr, .csN, .sclk, .mosi, .prdata);

//--- sim/spi_card_model.sv
// behavioural card on csN/sclk/mosi/miso, mode 0, msb first
// assumes the host makes sclk and holds csN low per transaction
`timescale 1ns/1ps
module spi_card_model (
  input  wire logic  csN,
  input  wire logic  sclk,
  input  wire logic  mosi,
  output logic       miso,
  output logic [5:0] lastIdx,
  output logic [31:0] lastArg,
  output int         halts,
  output int         polls
);
  logic [7:0] ib, ob = 8'hff, x, q[$];
  int n, fc, cnt, wr;
  bit wt;
  // released line shows the inverse, never a stale level
  assign miso = csN ? ~ob[7] : ob[7];
  always @(posedge csN)
  begin
    n = 0;
    ob = 8'hff;
  end
  always @(posedge sclk) if (!csN)
  begin
    ib = {ib[6:0], mosi};
    n = n + 1;
    if (n == 8)
    begin
      n = 0;
      take(ib);
    end
  end
  always @(negedge sclk) if (!csN) ob = (n == 0) ? (q.size() ? q.pop_front() : 8'hff) : ob << 1;
  // write block: data xor must be zero, then response and busy bytes
  task automatic take(input logic [7:0] b);
    if (wr > 0)
    begin
      wr--;
      if (wr > 1) x = x ^ b;
      if (wr == 0) q.push_back(x != 0 ? 8'h0b : 8'h05);
      if (wr == 0) repeat (2) q.push_back(8'h00);
    end
    else if (wt && b == 8'hfe)
    begin
      wt = 0;
      wr = 18;
      x = 0;
    end
    else if (fc == 0 && b[7:6] == 2'b01)
    begin
      fc = 1;
      lastIdx = b[5:0];
    end
    else if (fc > 0 && fc < 5)
    begin
      lastArg = {lastArg[23:0], b};
      fc++;
    end
    else if (fc == 5)
    begin
      fc = 0;
      answer();
    end
  endtask
  // idle bit until second init poll, illegal index flagged
  task automatic answer();
    int k;
    k = (lastIdx == 9) ? 1 : (lastIdx == 18) ? cnt : int'(lastIdx == 17);
    wt = lastIdx == 24;
    if (lastIdx == 1) polls++;
    q.push_back(lastIdx == 6 ? 8'h04 : (lastIdx == 0 || polls == 1 && lastIdx == 1) ? 8'h01 : 8'h00);
    if (lastIdx == 23) cnt = lastArg;
    if (lastIdx == 12) halts++;
    if (lastIdx == 13) q.push_back(8'h00);
    // error token or whole 16 byte blocks
    if (lastArg == '1 && k > 0) q.push_back(8'h08);
    else repeat (k)
    begin
      q.push_back(8'hfe);
      for (int i = 0; i < 16; i++) q.push_back(8'ha0 + i[7:0]);
      q.push_back(8'h5a);
      q.push_back(8'h5a);
    end
  endtask
endmodule

//--- sim/spi_card_host_tb_top.sv
// self-checking bench for spi_card_host against a card model
// assumes model data bytes a0+i and error token 08
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module spi_card_host_tb_top;
  import spi_card_pkg::*;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, csN, sclk, mosi, miso, pready;
  logic pslverr, ce = 1;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, arg, lastArg;
  logic [32:0] e, m, eq[$], mq[$];
  logic [5:0] lastIdx;
  int miscompares, tests_run, cyc, halts, polls;
  always #12.5 mclk = ~mclk;
  spi_card_host u_dut (.mclk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .csN, .sclk, .mosi, .miso);
  spi_card_model u_card (.csN, .sclk, .mosi, .miso, .lastIdx, .lastArg, .halts, .polls);
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  // compare each finished read with the oldest note
  always @(posedge mclk) if (psel && penable && pready === 1'b1 && !pwrite && eq.size())
  begin
    e = eq.pop_front();
    m = mq.pop_front();
    if (m != 0) `CHK("apb read", e & m, {pslverr, prdata} & m)
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] ex, mk);
    eq.push_back(ex);
    mq.push_back(mk);
    apb(0, a, 0);
  endtask
  task automatic idle();
    do rd(OFF_STAT, 0, 0); while (r[0] !== 1'b0);
  endtask
  task automatic op(input logic [5:0] c, input logic [31:0] a, input logic [7:0] ctl);
    apb(1, OFF_CMD, {26'h0, c});
    apb(1, OFF_ARG, a);
    apb(1, OFF_CTRL, {24'h0, ctl});
    idle();
  endtask
  // read k bytes through rx, stalling the link meanwhile
  task automatic getb(input int k);
    for (int i = 0; i < k; i++)
    begin
      do apb(0, OFF_STAT, 0); while (r[2] !== 1'b1);
      rd(OFF_RX, 33'ha0 + (i % 16), 33'hff);
      // freeze the whole block for a few cycles between bytes
      ce <= 0;
      repeat (1 + $urandom % 3) @(posedge mclk);
      ce <= 1;
    end
  endtask
  // single block write of random bytes; fix nonzero breaks the zero xor
  task automatic wrb(input logic [7:0] fix);
    logic [7:0] b, x;
    x = 0;
    apb(1, OFF_CMD, 32'h18);
    apb(1, OFF_ARG, $urandom);
    apb(1, OFF_CTRL, 32'h07);
    for (int i = 0; i < 16; i++)
    begin
      b = (i == 15) ? x ^ fix : 8'($urandom);
      x = x ^ b;
      do apb(0, OFF_STAT, 0); while (r[1] !== 1'b0);
      apb(1, OFF_TX, {24'h0, b});
    end
    idle();
  endtask
  initial
  begin
    void'($urandom(54426));
    repeat (12) @(posedge mclk);
    nrst <= 1;
    @(posedge mclk);
    rd(8'h40, 33'h1_0000_0000, '1);
    apb(1, OFF_BLEN, 32'h10);
    arg = $urandom & 32'h7fff_ffff;
    op(6'h10, arg, 8'h01);
    `CHK("frame", {6'h10, arg}, {lastIdx, lastArg})
    op(6'h06, 0, 8'h01);
    rd(OFF_STAT, 33'h0400, 33'hff01);
    op(6'h00, 0, 8'h09);
    rd(OFF_STAT, 33'h0, 33'hff20);
    `CHK("polls", 2, polls)
    apb(1, OFF_CMD, 32'h9);
    apb(1, OFF_ARG, 0);
    apb(1, OFF_CTRL, 32'h05);
    getb(16);
    idle();
    op(6'h11, '1, 8'h05);
    rd(OFF_STAT, 33'h0008_0008, 33'h00ff_0008);
    wrb(8'h00);
    rd(OFF_STAT, 33'h0005_0000, 33'h00ff_0010);
    `CHK("status cmd", 13, lastIdx)
    wrb(8'h01);
    rd(OFF_STAT, 33'h000b_0010, 33'h00ff_0010);
    apb(1, OFF_BCNT, 32'h2);
    apb(1, OFF_CMD, 32'h12);
    apb(1, OFF_ARG, 0);
    apb(1, OFF_CTRL, 32'h15);
    getb(32);
    idle();
    `CHK("halts", 0, halts)
    wrap_up();
  end
endmodule
